// ---- uart_flags_regs.vh ----
`ifndef UART_FLAGS_REGS_VH
`define UART_FLAGS_REGS_VH

// Register byte offsets
`define OFS_FLAG_STATUS 8'h18
`define OFS_DIV_INT 8'h24
`define OFS_DIV_FRAC 8'h28
`define OFS_LINE_CTRL 8'h2c
`define OFS_DATA 8'h00
`define OFS_IRQ_STATUS 8'h40
`define OFS_IRQ_MASK 8'h44

// Flag register bit positions
`define FLAG_TX_EMPTY 7
`define FLAG_RX_FULL 6
`define FLAG_TX_FULL 5
`define FLAG_RX_EMPTY 4
`define FLAG_BUSY 3

// Line control fields
`define LCR_QUEUE_MODE 4
`define LCR_TWO_STOP 3
`define LCR_WIDTH 8

// Field widths and reset values
`define DIV_INT_WIDTH 16
`define DIV_FRAC_WIDTH 6
`define DIV_INT_RESET 16'h0000
`define DIV_FRAC_RESET 6'h00
`define LCR_RESET 8'h00

// Interrupt status bits
`define IRQ_TX_EMPTY 0
`define IRQ_RX_AVAIL 1
`define IRQ_TX_DONE 2
`define IRQ_WIDTH 3

// Sampling ticks per bit
`define TICKS_PER_BIT 16

`endif

// ---- baud_tick_gen.v ----
`include "uart_flags_regs.vh"

// Fractional baud generator: one tick per (int + frac/64) clocks
module baud_tick_gen
(
  // System
  input wire clock,
  input wire reset_n,
  // Active divisor
  input wire [15:0] integer_divide_value,
  input wire [5:0] fractional_divide_value,
  // Tick out
  output reg tick
);

  reg [15:0] count_r;
  reg [6:0] fracAcc_r;
  wire [15:0] divEff;
  wire [6:0] fracSum;

  // Zero divisor behaves as divide by one
  assign divEff = (integer_divide_value == 16'h0000) ? 16'h0001 : integer_divide_value; // R8
  assign fracSum = {1'b0, fracAcc_r[5:0]} + {1'b0, fractional_divide_value};

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_r <= 16'h0000;
      fracAcc_r <= 7'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (count_r == 16'h0000)
      begin
        // Carry out of the fraction stretches this period by one clock
        tick <= 1'b1; // R15
        fracAcc_r <= {1'b0, fracSum[5:0]};
        count_r <= fracSum[6] ? divEff : divEff - 16'h0001;
      end
      else
      begin
        count_r <= count_r - 16'h0001;
      end
    end
  end

endmodule

// ---- uart_flags_core.v ----
// Implementation choice: the Wishbone interface to the registers.
`include "uart_flags_regs.vh"

// What this block does
// R1: Reset clears full and busy, sets empties
// R2: Bit 7 flags transmit queue empty
// R3: Bit 6 flags receive queue full
// R4: Bit 5 flags transmit queue full
// R5: Bit 4 flags receive queue empty
// R6: Busy holds until last stop bit sent
// R7: Busy rises on queue non-empty, enable ignored
// R8: 16-bit integer divisor, zero means one
// R9: New divisor waits for character end
// R10: 6-bit fraction, reset zero, upper reserved
// R11: Line control write commits the divisors
// R12: Software writes line control after divisor change
// R13: Reserved bits read zero, writes ignored
// R14: Queue mode bit selects queue or single
// R15: Bit rate is clock over 16 times divisor
module uart_flags_core
#(
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  // System
  input wire clock,
  input wire reset_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Serial line
  input wire rxIn,
  output reg txOut,
  // Interrupt
  output reg irq
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_STOP = 4'b1000;

  // =========================================================
  // Registers
  // =========================================================
  reg [15:0] divIntShadow_r;
  reg [5:0] divFracShadow_r;
  reg [15:0] divIntPend_r;
  reg [5:0] divFracPend_r;
  reg [15:0] divIntAct_r;
  reg [5:0] divFracAct_r;
  reg pend_r;
  reg [7:0] lineCtrl_r;
  reg [`IRQ_WIDTH-1:0] irqStat_r;
  reg [`IRQ_WIDTH-1:0] irqMask_r;
  reg [`IRQ_WIDTH-1:0] irqStat_nxt;

  reg [7:0] txMem [0:DEPTH-1];
  reg [7:0] rxMem [0:DEPTH-1];
  reg [AW:0] txCnt_r;
  reg [AW:0] rxCnt_r;
  reg [AW-1:0] txWr_r;
  reg [AW-1:0] txRd_r;
  reg [AW-1:0] rxWr_r;
  reg [AW-1:0] rxRd_r;

  reg [3:0] txState_r;
  reg [3:0] txTick_r;
  reg [3:0] txBit_r;
  reg [7:0] txShift_r;
  reg [3:0] rxState_r;
  reg [3:0] rxTick_r;
  reg [3:0] rxBit_r;
  reg [7:0] rxShift_r;

  wire tick;
  wire access;
  wire wrAcc;
  wire rdAcc;
  wire queueMode;
  wire [AW:0] capacity;
  wire txEmpty;
  wire txFull;
  wire rxEmpty;
  wire rxFull;
  wire busy;
  wire txPush;
  wire txPop;
  wire rxPush;
  wire rxPop;
  wire txLineIdle;
  wire rxLineIdle;
  wire [7:0] flags;
  reg [31:0] rdData;

  function wr_hit;
    input [7:0] ofs;
    begin
      wr_hit = wrAcc && (wb_adr_i == ofs);
    end
  endfunction

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrAcc = access && wb_we_i && wb_sel_i[0];
  assign rdAcc = access && !wb_we_i;
  assign queueMode = lineCtrl_r[`LCR_QUEUE_MODE]; // R14
  assign capacity = queueMode ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1}; // R14

  // =========================================================
  // Flags
  // =========================================================
  assign txEmpty = (txCnt_r == {(AW+1){1'b0}}); // R2
  assign txFull = (txCnt_r >= capacity); // R4
  assign rxEmpty = (rxCnt_r == {(AW+1){1'b0}}); // R5
  assign rxFull = (rxCnt_r >= capacity); // R3
  // Queued data counts as busy before the shifter starts
  assign busy = !txEmpty || (txState_r != ST_IDLE); // R6 R7
  assign flags = {txEmpty, rxFull, txFull, rxEmpty, busy, 3'b000}; // R1 R13

  // =========================================================
  // Queues
  // =========================================================
  assign txPush = wr_hit(`OFS_DATA) && !txFull;
  assign txPop = (txState_r == ST_IDLE) && !txEmpty && tick;
  assign rxPop = rdAcc && (wb_adr_i == `OFS_DATA) && !rxEmpty;
  assign rxPush = (rxState_r == ST_STOP) && tick && (rxTick_r == 4'h7) && !rxFull;

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txCnt_r <= {(AW+1){1'b0}};
      rxCnt_r <= {(AW+1){1'b0}};
      txWr_r <= {AW{1'b0}};
      txRd_r <= {AW{1'b0}};
      rxWr_r <= {AW{1'b0}};
      rxRd_r <= {AW{1'b0}};
    end
    else
    begin
      if (txPush)
        txWr_r <= queueMode ? txWr_r + 1'b1 : {AW{1'b0}};
      if (txPop)
        txRd_r <= queueMode ? txRd_r + 1'b1 : {AW{1'b0}};
      txCnt_r <= txCnt_r + {{AW{1'b0}}, txPush} - {{AW{1'b0}}, txPop};
      if (rxPush)
        rxWr_r <= queueMode ? rxWr_r + 1'b1 : {AW{1'b0}};
      if (rxPop)
        rxRd_r <= queueMode ? rxRd_r + 1'b1 : {AW{1'b0}};
      rxCnt_r <= rxCnt_r + {{AW{1'b0}}, rxPush} - {{AW{1'b0}}, rxPop};
    end
  end

  always @(posedge clock)
  begin
    if (txPush)
      txMem[txWr_r] <= wb_dat_i[7:0];
    if (rxPush)
      rxMem[rxWr_r] <= rxShift_r;
  end

  // =========================================================
  // Divisor commit
  // =========================================================
  assign txLineIdle = (txState_r == ST_IDLE);
  assign rxLineIdle = (rxState_r == ST_IDLE);

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divIntShadow_r <= `DIV_INT_RESET;
      divFracShadow_r <= `DIV_FRAC_RESET;
      divIntPend_r <= `DIV_INT_RESET;
      divFracPend_r <= `DIV_FRAC_RESET;
      divIntAct_r <= `DIV_INT_RESET;
      divFracAct_r <= `DIV_FRAC_RESET;
      pend_r <= 1'b0;
      lineCtrl_r <= `LCR_RESET;
    end
    else
    begin
      if (wrAcc && wb_adr_i == `OFS_DIV_INT)
      begin
        divIntShadow_r[7:0] <= wb_dat_i[7:0]; // R8
        if (wb_sel_i[1])
          divIntShadow_r[15:8] <= wb_dat_i[15:8]; // R8
      end
      if (wr_hit(`OFS_DIV_FRAC))
        divFracShadow_r <= wb_dat_i[5:0]; // R10
      if (wr_hit(`OFS_LINE_CTRL))
      begin
        lineCtrl_r <= wb_dat_i[7:0];
        // Shadows reach the generator only through this strobe
        divIntPend_r <= divIntShadow_r; // R11 R12
        divFracPend_r <= divFracShadow_r; // R11 R12
        pend_r <= 1'b1;
      end
      else if (pend_r && txLineIdle && rxLineIdle)
      begin
        // Applied only between characters to avoid a torn bit period
        divIntAct_r <= divIntPend_r; // R9
        divFracAct_r <= divFracPend_r; // R9
        pend_r <= 1'b0;
      end
    end
  end

  baud_tick_gen u_baud
  (
    .clock(clock),
    .reset_n(reset_n),
    .integer_divide_value(divIntAct_r),
    .fractional_divide_value(divFracAct_r),
    .tick(tick)
  );

  // =========================================================
  // Transmitter (8N1, optional second stop bit)
  // =========================================================
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txState_r <= ST_IDLE;
      txTick_r <= 4'h0;
      txBit_r <= 4'h0;
      txShift_r <= 8'h00;
      txOut <= 1'b1;
    end
    else if (tick)
    begin
      case (txState_r)
        ST_IDLE:
        begin
          txOut <= 1'b1;
          if (!txEmpty)
          begin
            txShift_r <= txMem[txRd_r];
            txState_r <= ST_START;
            txTick_r <= 4'h0;
            txOut <= 1'b0;
          end
        end
        ST_START:
        begin
          txTick_r <= txTick_r + 4'h1;
          if (txTick_r == 4'hf)
          begin
            txState_r <= ST_DATA;
            txBit_r <= 4'h0;
            txOut <= txShift_r[0];
          end
        end
        ST_DATA:
        begin
          txTick_r <= txTick_r + 4'h1;
          if (txTick_r == 4'hf)
          begin
            txShift_r <= {1'b0, txShift_r[7:1]};
            txBit_r <= txBit_r + 4'h1;
            txOut <= (txBit_r == 4'h7) ? 1'b1 : txShift_r[1];
            if (txBit_r == 4'h7)
            begin
              txState_r <= ST_STOP;
              txBit_r <= lineCtrl_r[`LCR_TWO_STOP] ? 4'h1 : 4'h0;
            end
          end
        end
        ST_STOP:
        begin
          txTick_r <= txTick_r + 4'h1;
          if (txTick_r == 4'hf)
          begin
            // Busy only drops once every stop bit is out
            if (txBit_r == 4'h0)
              txState_r <= ST_IDLE; // R6
            else
              txBit_r <= txBit_r - 4'h1;
          end
        end
        default:
          txState_r <= ST_IDLE;
      endcase
    end
  end

  // =========================================================
  // Receiver (mid-bit sampling)
  // =========================================================
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxState_r <= ST_IDLE;
      rxTick_r <= 4'h0;
      rxBit_r <= 4'h0;
      rxShift_r <= 8'h00;
    end
    else if (tick)
    begin
      rxTick_r <= rxTick_r + 4'h1;
      case (rxState_r)
        ST_IDLE:
        begin
          rxTick_r <= 4'h0;
          if (!rxIn)
            rxState_r <= ST_START;
        end
        ST_START:
        begin
          if (rxTick_r == 4'h7)
          begin
            rxTick_r <= 4'h0;
            rxBit_r <= 4'h0;
            rxState_r <= rxIn ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (rxTick_r == 4'hf)
          begin
            rxShift_r <= {rxIn, rxShift_r[7:1]};
            rxBit_r <= rxBit_r + 4'h1;
            if (rxBit_r == 4'h7)
              rxState_r <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          // Overrun: character dropped when queue full
          if (rxTick_r == 4'h7)
            rxState_r <= ST_IDLE;
        end
        default:
          rxState_r <= ST_IDLE;
      endcase
    end
  end

  // =========================================================
  // Interrupts and bus answer
  // =========================================================
  always @*
  begin
    irqStat_nxt = irqStat_r;
    if (wr_hit(`OFS_IRQ_STATUS))
      irqStat_nxt = irqStat_nxt & ~wb_dat_i[`IRQ_WIDTH-1:0];
    // Set wins over a simultaneous clear
    if (txPop && txCnt_r == {{AW{1'b0}}, 1'b1})
      irqStat_nxt[`IRQ_TX_EMPTY] = 1'b1;
    if (rxPush)
      irqStat_nxt[`IRQ_RX_AVAIL] = 1'b1;
    if (tick && txState_r == ST_STOP && txTick_r == 4'hf && txBit_r == 4'h0)
      irqStat_nxt[`IRQ_TX_DONE] = 1'b1;
  end

  always @*
  begin
    case (wb_adr_i)
      `OFS_DATA: rdData = {24'h000000, rxMem[rxRd_r]};
      `OFS_FLAG_STATUS: rdData = {24'h000000, flags};
      `OFS_DIV_INT: rdData = {16'h0000, divIntShadow_r};
      `OFS_DIV_FRAC: rdData = {26'h0, divFracShadow_r}; // R10 R13
      `OFS_LINE_CTRL: rdData = {24'h000000, lineCtrl_r};
      `OFS_IRQ_STATUS: rdData = {29'h0, irqStat_r};
      `OFS_IRQ_MASK: rdData = {29'h0, irqMask_r};
      default: rdData = 32'h00000000;
    endcase
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqStat_r <= {`IRQ_WIDTH{1'b0}};
      irqMask_r <= {`IRQ_WIDTH{1'b0}};
      irq <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      irqStat_r <= irqStat_nxt;
      if (wr_hit(`OFS_IRQ_MASK))
        irqMask_r <= wb_dat_i[`IRQ_WIDTH-1:0];
      irq <= |(irqStat_nxt & irqMask_r);
      wb_ack_o <= access;
      wb_dat_o <= rdAcc ? rdData : 32'h00000000;
    end
  end

endmodule

// ---- uart_flags_chk.sv ----
`include "uart_flags_regs.vh"

module uart_flags_chk
(
  // System
  input wire clock,
  input wire reset_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Serial line and interrupt
  input wire rxIn,
  input wire txOut,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // ========
  // Read answers, address still held by the master
  wire rdAck = wb_ack_o && !wb_we_i;
  wire [31:0] d = wb_dat_o;
  wire flagRd = rdAck && wb_adr_i == `OFS_FLAG_STATUS;

  ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  idle_data_zero_a: assert property (!wb_ack_o |-> d == 32'h0)
    else $error("read data outside ack");
  flag_reserved_a: assert property (flagRd |-> d[31:8] == 24'h0 && d[2:0] == 3'h0)
    else $error("flag reserved bits set");
  tx_flags_excl_a: assert property (flagRd |-> !(d[`FLAG_TX_EMPTY] && d[`FLAG_TX_FULL]))
    else $error("tx empty and full together");
  rx_flags_excl_a: assert property (flagRd |-> !(d[`FLAG_RX_EMPTY] && d[`FLAG_RX_FULL]))
    else $error("rx empty and full together");
  busy_on_queue_a: assert property (flagRd && !d[`FLAG_TX_EMPTY] |-> d[`FLAG_BUSY])
    else $error("tx data queued but not busy");
  int_width_a: assert property (rdAck && wb_adr_i == `OFS_DIV_INT |-> d[31:16] == 16'h0)
    else $error("integer divisor wider than 16 bits");
  frac_width_a: assert property (rdAck && wb_adr_i == `OFS_DIV_FRAC |-> d[31:6] == 26'h0)
    else $error("fraction wider than 6 bits");
  irq_masked_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == `OFS_IRQ_MASK
    && wb_dat_i[2:0] == 3'h0 |-> ##[1:2] !irq) else $error("irq with all masked");
endmodule

bind uart_flags_core uart_flags_chk u_chk (.clock(clock), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rxIn(rxIn), .txOut(txOut), .irq(irq));

// ---- serial_peer.sv ----
module serial_peer
(
  // System
  input wire logic clock,
  // Serial line
  input wire logic txOut,
  output logic rxIn
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitClk = 16;
  logic [7:0] got[$];
  initial rxIn = 1'b1;

  // ========
  // Start low, data low bit first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      rxIn <= f[i];
      repeat (bitClk - 1) @(posedge clock);
    end
  endtask

  // Mid-bit sampling; a low stop bit drops the frame
  always @(negedge txOut)
  begin
    logic [8:0] f;
    repeat (bitClk / 2) @(posedge clock);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bitClk) @(posedge clock);
      f[i] = txOut;
    end
    if (f[8] === 1'b1)
      got.push_back(f[7:0]);
  end
endmodule

// ---- tb.sv ----
`include "uart_flags_regs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, cyc, stb, we, ack, rxIn, txOut, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, datO;
  logic [7:0] txExp [8] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h11, 8'h22, 8'h44, 8'h55};
  int numErrors, cmpCount;

  uart_flags_core u_dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO),
    .wb_ack_o(ack), .rxIn(rxIn), .txOut(txOut), .irq(irq));
  serial_peer u_peer (.clock(clock), .txOut(txOut), .rxIn(rxIn));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ========
  // Bus tasks
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    @(posedge clock);
    while (ack !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 100)
    begin
      numErrors++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    check(what, rdat, exp);
  endtask

  // Poll until the transmitter is idle
  task automatic waitIdle();
    int n;
    for (n = 0; n < 3000; n++)
    begin
      xfer(1'b0, `OFS_FLAG_STATUS, 32'h0);
      if (rdat[`FLAG_BUSY] === 1'b0)
        break;
    end
    check("idle wait", n < 3000, 1'b1);
    if (n >= 3000)
      finish_test();
  endtask

  // ========
  // Main sequence
  initial
  begin
    {cyc, stb, we, adr, wdat, reset_n, numErrors, cmpCount} = '0;
    sel = 4'hf;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    rd(`OFS_FLAG_STATUS, 32'h90, "reset flags");
    rd(`OFS_DIV_INT, 32'h0, "reset int");
    rd(`OFS_DIV_FRAC, 32'h0, "reset frac");
    rd(8'h3c, 32'h0, "unmapped");
    xfer(1'b1, `OFS_DIV_INT, 32'hffffffff);
    rd(`OFS_DIV_INT, 32'h0000ffff, "int width");
    xfer(1'b1, `OFS_DIV_FRAC, 32'hffffffff);
    rd(`OFS_DIV_FRAC, 32'h3f, "frac width");
    xfer(1'b1, `OFS_DIV_FRAC, 32'h0);
    xfer(1'b1, `OFS_DIV_INT, 32'h4);
    // Divisor 4 stays pending: zero divisor gives 16 clocks a bit
    xfer(1'b1, `OFS_DATA, 32'ha5);
    xfer(1'b1, `OFS_DATA, 32'h3c);
    rd(`OFS_FLAG_STATUS, 32'h38, "char mode tx flags");
    waitIdle();
    xfer(1'b1, `OFS_DATA, 32'h5a);
    xfer(1'b1, `OFS_LINE_CTRL, 32'h0);
    waitIdle();
    check("tx count", u_peer.got.size(), 32'd3);
    u_peer.bitClk = 64;
    xfer(1'b1, `OFS_DATA, 32'hc3);
    waitIdle();
    check("tx count", u_peer.got.size(), 32'd4);
    xfer(1'b1, `OFS_IRQ_MASK, 32'h2);
    u_peer.send(8'h96);
    repeat (2) @(posedge clock);
    rd(`OFS_FLAG_STATUS, 32'hc0, "char mode rx flags");
    check("irq raised", irq, 1'b1);
    rd(`OFS_DATA, 32'h96, "rx data");
    xfer(1'b1, `OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clock);
    check("irq cleared", irq, 1'b0);
    xfer(1'b1, `OFS_IRQ_MASK, 32'h0);
    xfer(1'b1, `OFS_LINE_CTRL, 32'h10);
    for (int i = 0; i < 16; i++)
    begin
      u_peer.send(8'(i));
      if (i == 0)
        rd(`OFS_FLAG_STATUS, 32'h80, "queue one entry");
    end
    repeat (2) @(posedge clock);
    rd(`OFS_FLAG_STATUS, 32'hc0, "queue full");
    check("irq masked", irq, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      xfer(1'b0, `OFS_DATA, 32'h0);
      check("queue data", rdat[7:0], 8'(i));
    end
    rd(`OFS_FLAG_STATUS, 32'h90, "queue drained");
    xfer(1'b1, `OFS_DATA, 32'h11);
    xfer(1'b1, `OFS_DATA, 32'h22);
    rd(`OFS_FLAG_STATUS, 32'h18, "queue mode tx flags");
    waitIdle();
    check("tx count", u_peer.got.size(), 32'd6);
    // Fraction held back until the line control strobe
    xfer(1'b1, `OFS_DIV_FRAC, 32'h20);
    xfer(1'b1, `OFS_DATA, 32'h44);
    waitIdle();
    xfer(1'b1, `OFS_LINE_CTRL, 32'h18);
    // 4.5 clocks a tick, two stop bits
    u_peer.bitClk = 72;
    xfer(1'b1, `OFS_DATA, 32'h55);
    for (int n = 0; n < 2000 && u_peer.got.size() < 8; n++)
      @(posedge clock);
    check("frame seen", u_peer.got.size(), 32'd8);
    // Mid second stop bit: one stop would already be idle
    repeat (72) @(posedge clock);
    rd(`OFS_FLAG_STATUS, 32'h98, "second stop busy");
    waitIdle();
    check("tx count", u_peer.got.size(), 32'd8);
    for (int i = 0; i < 8 && i < u_peer.got.size(); i++)
      check("tx byte", u_peer.got[i], txExp[i]);
    finish_test();
  end
endmodule
